// File: rtl/pmc_power_capability.sv
// Power capability report register with ROM-loaded cold-wake support bit
//
// Functional notes
// RQ1: Bit 15 mirrors cold-wake support bit 15 of miscellaneous register at F0h.
// RQ2: Miscellaneous register is loaded from the external ROM.
// RQ3: Bits 14..11 read all ones: wake from D3hot, D2, D1, D0.
// RQ4: Bit 10 is tied to one: second low-power state supported.
// RQ5: Bit 9 is tied to one: first low-power state supported.
// RQ6: Bits 8..6 read 000b when bit 15 clear, 001b when set.
// RQ7: Bit 5 reads zero: no special initialization needed.
// RQ8: Reserved bit 4 reads zero.
// RQ9: Bit 3 reads zero: no host clock needed to wake.
// RQ10: Bits 2..0 read 010b, spec revision 1.1.
// RQ11: Register at offset 46h, resets to 7E02h, only bit 15 and the bits 8..6 code that follows it hardware-updated.
// RQ12: Writes to the register are acknowledged but change nothing.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_capability
    import pmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire pmc_cfg_req_t cfg_req,
    output pmc_cfg_rsp_t cfg_rsp,
    output logic rom_req,
    input wire logic rom_ack,
    input wire logic [31:0] rom_data,
    output logic misc_loaded
);

    // Assemble the report from the cold-wake bit; every field other than bits 15 and 8..6 is fixed
    function automatic logic [15:0] build_report(input logic wake_cold);
        logic [15:0] r;
        r = '0;
        r[PMC_WAKE_COLD_BIT] = wake_cold; // [RQ1]
        r[PMC_WAKE_MASK_MSB:PMC_WAKE_MASK_LSB] = PMC_WAKE_MASK_VAL; // [RQ3]
        r[PMC_SECOND_LP_BIT] = 1'b1; // [RQ4]
        r[PMC_FIRST_LP_BIT] = 1'b1; // [RQ5]
        r[PMC_AUX_MSB:PMC_AUX_LSB] = wake_cold ? PMC_AUX_55MA : PMC_AUX_SELF; // [RQ6]
        r[PMC_INIT_BIT] = 1'b0; // [RQ7]
        r[PMC_RSVD_BIT] = 1'b0; // [RQ8]
        r[PMC_CLK_BIT] = 1'b0; // [RQ9]
        r[PMC_REV_MSB:PMC_REV_LSB] = PMC_REV_VAL; // [RQ10]
        return r;
    endfunction

    // Dword match on a configuration byte offset
    function automatic logic dw_match(input logic [7:0] a, input logic [7:0] target);
        return a[7:PMC_ADDR_DW_LSB] == target[7:PMC_ADDR_DW_LSB];
    endfunction

    pmc_state_t state_reg;
    logic [31:0] misc_reg;
    logic [15:0] cap_reg;
    logic cap_hit;
    logic [31:0] read_next;

    assign cap_hit = dw_match(cfg_req.addr, PMC_CAP_OFFSET);

    // ROM load sequencer: fetch once after reset, then hold
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= PMC_ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                PMC_ST_IDLE: state_reg <= PMC_ST_FETCH;
                PMC_ST_FETCH:
                begin
                    if (rom_ack)
                    begin
                        state_reg <= PMC_ST_DONE; // [RQ2]
                    end
                end
                PMC_ST_DONE: state_reg <= PMC_ST_DONE;
                default: state_reg <= PMC_ST_IDLE;
            endcase
        end
    end

    // Request and done flags come from flops so the ROM side sees clean levels
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rom_req <= 1'b0;
            misc_loaded <= 1'b0;
        end
        else
        begin
            rom_req <= (state_reg == PMC_ST_IDLE)
                || (state_reg == PMC_ST_FETCH && !rom_ack);
            misc_loaded <= misc_loaded || (state_reg == PMC_ST_FETCH && rom_ack);
        end
    end

    // Miscellaneous register image, taken from the ROM word
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            misc_reg <= PMC_MISC_RESET;
        end
        else if (state_reg == PMC_ST_FETCH && rom_ack)
        begin
            misc_reg <= rom_data; // [RQ2]
        end
    end

    // Report follows the misc bit; host writes never reach it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_reg <= PMC_CAP_RESET; // [RQ11]
        end
        else
        begin
            cap_reg <= build_report(misc_reg[PMC_MISC_WAKE_BIT]); // [RQ1] [RQ11] [RQ12]
        end
    end

    // Read data: report in the upper half-word, lower half belongs elsewhere
    always_comb
    begin
        read_next = '0;
        if (cfg_req.rd && cap_hit)
        begin
            read_next[PMC_CAP_HALF_LSB +: 16] = cap_reg; // [RQ11]
        end
    end

    // Answer one cycle after every access; writes are acked and dropped
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_rsp <= '0;
        end
        else
        begin
            cfg_rsp.ack <= cfg_req.rd || cfg_req.wr; // [RQ12]
            cfg_rsp.hit <= (cfg_req.rd || cfg_req.wr) && cap_hit;
            cfg_rsp.rdata <= read_next;
        end
    end

    // Checks
    logic past_valid;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            past_valid <= 1'b0;
        else
            past_valid <= 1'b1;
    end

    a_wake_mirror: assert property (@(posedge clock) disable iff (!rst_b) // [RQ1]
        past_valid |-> cap_reg[PMC_WAKE_COLD_BIT] == $past(misc_reg[PMC_MISC_WAKE_BIT]))
        else $error("wake bit does not follow misc register");
    a_rom_load: assert property (@(posedge clock) disable iff (!rst_b) // [RQ2]
        (state_reg == PMC_ST_FETCH && rom_ack) |=> misc_reg == $past(rom_data) && misc_loaded)
        else $error("misc register not loaded from ROM");
    a_wake_mask: assert property (@(posedge clock) disable iff (!rst_b) // [RQ3]
        cap_reg[PMC_WAKE_MASK_MSB:PMC_WAKE_MASK_LSB] == 4'hf)
        else $error("wake mask not all ones");
    a_lp_support: assert property (@(posedge clock) disable iff (!rst_b) // [RQ4]
        cap_reg[PMC_SECOND_LP_BIT] && cap_reg[PMC_FIRST_LP_BIT])
        else $error("low-power support bits not set");
    a_first_lp: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
        cfg_rsp.ack && cfg_rsp.hit && $past(cfg_req.rd) |-> cfg_rsp.rdata[25])
        else $error("first low-power bit missing on read");
    a_aux_code: assert property (@(posedge clock) disable iff (!rst_b) // [RQ6]
        cap_reg[PMC_AUX_MSB:PMC_AUX_LSB] == {2'b00, cap_reg[PMC_WAKE_COLD_BIT]})
        else $error("aux current code inconsistent with wake bit");
    a_zero_bits: assert property (@(posedge clock) disable iff (!rst_b) // [RQ7] [RQ8] [RQ9]
        cap_reg[PMC_INIT_BIT:PMC_CLK_BIT] == 3'h0)
        else $error("bits 5..3 not zero");
    a_spec_rev: assert property (@(posedge clock) disable iff (!rst_b) // [RQ10]
        cap_reg[PMC_REV_MSB:PMC_REV_LSB] == 3'h2)
        else $error("revision field wrong");
    a_read_data: assert property (@(posedge clock) disable iff (!rst_b) // [RQ11]
        (cfg_req.rd && cap_hit) |=> cfg_rsp.ack && cfg_rsp.rdata[31:16] == $past(cap_reg))
        else $error("read returned wrong report");
    a_write_ignored: assert property (@(posedge clock) disable iff (!rst_b) // [RQ12]
        (cfg_req.wr && cap_hit && $stable(misc_reg)) ##1 $stable(misc_reg)
        |-> cfg_rsp.ack && cfg_rsp.hit && $stable(cap_reg) ##1 $stable(cap_reg))
        else $error("write changed report or was not acked");

    // Answer timing and idle read data
    a_ack_timing: assert property (@(posedge clock) disable iff (!rst_b) // [RQ12]
        past_valid |-> cfg_rsp.ack == $past(cfg_req.rd || cfg_req.wr))
        else $error("ack not one cycle after access");
    a_miss_quiet: assert property (@(posedge clock) disable iff (!rst_b) // [RQ11]
        past_valid && !$past(cfg_req.rd && cap_hit) |-> cfg_rsp.rdata == 32'h0000_0000)
        else $error("read data not zero outside a read hit");
    a_hit_with_ack: assert property (@(posedge clock) disable iff (!rst_b) // [RQ11]
        cfg_rsp.hit |-> cfg_rsp.ack)
        else $error("hit without ack");
    // Single load per reset; late ROM answers must not disturb the image
    a_single_load: assert property (@(posedge clock) disable iff (!rst_b) // [RQ2]
        misc_loaded |=> $stable(misc_reg) && misc_loaded)
        else $error("misc register changed after load");
    a_req_release: assert property (@(posedge clock) disable iff (!rst_b) // [RQ2]
        misc_loaded |-> !rom_req)
        else $error("ROM request still raised after load");

    c_read_hit: cover property (@(posedge clock) disable iff (!rst_b)
        cfg_req.rd && cap_hit ##1 cfg_rsp.ack);
    c_write_hit: cover property (@(posedge clock) disable iff (!rst_b)
        cfg_req.wr && cap_hit ##1 cfg_rsp.hit);
    c_wake_set: cover property (@(posedge clock) disable iff (!rst_b)
        cap_reg[PMC_WAKE_COLD_BIT]);
    c_read_miss: cover property (@(posedge clock) disable iff (!rst_b)
        cfg_req.rd && !cap_hit ##1 cfg_rsp.ack && !cfg_rsp.hit);
    c_late_ack: cover property (@(posedge clock) disable iff (!rst_b)
        misc_loaded && rom_ack);

endmodule
`default_nettype wire

// File: rtl/pmc_pkg.sv
// Shared constants and carrier types for the power capability report block
package pmc_pkg;
    // Configuration byte offsets
    localparam logic [7:0] PMC_CAP_OFFSET = 8'h46;
    localparam logic [7:0] PMC_MISC_OFFSET = 8'hf0;
    // Dword holding the report sits in the upper half-word of that dword
    localparam int PMC_CAP_HALF_LSB = 16;
    localparam int PMC_ADDR_DW_LSB = 2;
    // Report layout
    localparam logic [15:0] PMC_CAP_RESET = 16'h7e02;
    localparam int PMC_WAKE_COLD_BIT = 15;
    localparam int PMC_WAKE_MASK_MSB = 14;
    localparam int PMC_WAKE_MASK_LSB = 11;
    localparam int PMC_SECOND_LP_BIT = 10;
    localparam int PMC_FIRST_LP_BIT = 9;
    localparam int PMC_AUX_MSB = 8;
    localparam int PMC_AUX_LSB = 6;
    localparam int PMC_INIT_BIT = 5;
    localparam int PMC_RSVD_BIT = 4;
    localparam int PMC_CLK_BIT = 3;
    localparam int PMC_REV_MSB = 2;
    localparam int PMC_REV_LSB = 0;
    // Field values
    localparam logic [3:0] PMC_WAKE_MASK_VAL = 4'hf;
    localparam logic [2:0] PMC_AUX_SELF = 3'h0;
    localparam logic [2:0] PMC_AUX_55MA = 3'h1;
    localparam logic [2:0] PMC_REV_VAL = 3'h2;
    // Miscellaneous register: bit that carries cold-wake support
    localparam int PMC_MISC_WAKE_BIT = 15;
    localparam logic [31:0] PMC_MISC_RESET = 32'h0000_0000;

    // Loader states, one-hot
    typedef enum logic [2:0] {
        PMC_ST_IDLE = 3'b001,
        PMC_ST_FETCH = 3'b010,
        PMC_ST_DONE = 3'b100
    } pmc_state_t;

    // Configuration request from the bus front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmc_cfg_req_t;

    // Configuration answer
    typedef struct packed {
        logic ack;
        logic hit;
        logic [31:0] rdata;
    } pmc_cfg_rsp_t;
endpackage

// File: sim/pmc_rom_model.sv
// Behavioural ROM controller that supplies the miscellaneous register word
`timescale 1ns/1ps
`default_nettype none
module pmc_rom_model
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic rom_req,
    input wire logic [7:0] delay,
    input wire logic [31:0] word,
    input wire logic extra,
    output logic rom_ack,
    output logic [31:0] rom_data
);
    logic [7:0] wait_reg;

    // One answer per request after delay cycles, plus one on each cycle that extra is high; data toggles when not valid
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_reg <= 8'h00;
            rom_ack <= 1'h0;
            rom_data <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= rom_req ? wait_reg + 8'h01 : 8'h00;
            rom_ack <= (rom_req && wait_reg == delay && !rom_ack) || extra;
            rom_data <= ((rom_req && wait_reg == delay) || extra) ? word : ~rom_data;
        end
    end
endmodule
`default_nettype wire

// File: sim/pmc_testbench.sv
// Self-checking bench for the power capability report register
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmc_pkg::*;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic extra = 1'h0;
    logic [31:0] word = 32'h0000_0000;
    logic [7:0] delay = 8'h28;
    pmc_cfg_req_t cfg_req = '0;
    pmc_cfg_rsp_t cfg_rsp;
    pmc_cfg_rsp_t rsp;
    logic rom_req;
    logic rom_ack;
    logic misc_loaded;
    logic [31:0] rom_data;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    pmc_power_capability pmc_power_capability_inst (.clock(clock), .rst_b(rst_b),
        .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rom_req(rom_req), .rom_ack(rom_ack),
        .rom_data(rom_data), .misc_loaded(misc_loaded));
    pmc_rom_model pmc_rom_model_inst (.clock(clock), .rst_b(rst_b), .rom_req(rom_req),
        .delay(delay), .word(word), .extra(extra), .rom_ack(rom_ack), .rom_data(rom_data));

    // Free-running clock
    initial
    begin
        forever #5 clock = ~clock;
    end

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, the sequence needs about 150 cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Expected report built field by field from the cold-wake bit
    function automatic logic [15:0] report(input logic cold);
        return {cold, 4'hf, 1'h1, 1'h1, cold ? 3'h1 : 3'h0, 1'h0, 1'h0, 1'h0, 3'h2};
    endfunction

    // One strobe pulse; answer is looked at after the edge that registers it
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clock);
        cfg_req <= '{rd: !wr, wr: wr, addr: addr, be: 4'hf, wdata: wdata};
        @(posedge clock);
        cfg_req <= '0;
        #1;
        rsp = cfg_rsp;
        check({31'h0, rsp.ack}, 32'h1, "ack");
    endtask

    task automatic do_reset(input logic [31:0] w, input logic [7:0] d);
        @(posedge clock);
        rst_b <= 1'h0;
        word <= w;
        delay <= d;
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
    endtask

    // Slowest ROM answer here is about forty cycles; sixty leaves margin
    task automatic wait_load();
        repeat (60) @(posedge clock);
        #1;
        check({31'h0, misc_loaded}, 32'h1, "loaded");
        check({31'h0, rom_req}, 32'h0, "request dropped");
    endtask

    task automatic fresh_defaults();
        do_reset(32'h0000_8000, 8'h28);
        #1;
        check({31'h0, misc_loaded}, 32'h0, "not loaded");
        access(1'h0, 8'h46, 32'h0);
        check({31'h0, rom_req}, 32'h1, "fetch pending");
        check({31'h0, rsp.hit}, 32'h1, "reset hit");
        check(rsp.rdata, {report(1'h0), 16'h0}, "reset");
        access(1'h1, 8'h46, 32'hffff_ffff);
        check({31'h0, rsp.hit}, 32'h1, "write hit");
        check(rsp.rdata, 32'h0, "write answer");
        access(1'h0, 8'h46, 32'h0);
        check(rsp.rdata, {report(1'h0), 16'h0}, "after write");
        access(1'h0, 8'hf0, 32'h0);
        check({31'h0, rsp.hit}, 32'h0, "miss hit");
        check(rsp.rdata, 32'h0, "miss");
    endtask

    task automatic cold_load();
        wait_load();
        access(1'h0, 8'h44, 32'h0);
        check(rsp.rdata, {report(1'h1), 16'h0}, "cold set");
        @(posedge clock);
        word <= 32'h0000_0000;
        extra <= 1'h1;
        @(posedge clock);
        extra <= 1'h0;
        access(1'h1, 8'h46, 32'h0000_0000);
        repeat (3) @(posedge clock);
        access(1'h0, 8'h46, 32'h0);
        check(rsp.rdata, {report(1'h1), 16'h0}, "single load");
    endtask

    task automatic reload_clear();
        do_reset(32'hffff_7fff, 8'h02);
        wait_load();
        access(1'h0, 8'h46, 32'h0);
        check(rsp.rdata, {report(1'h0), 16'h0}, "cold clear");
    endtask

    initial
    begin
        fresh_defaults();
        cold_load();
        reload_clear();
        summarize();
    end
endmodule
`default_nettype wire
